// ---- rtl/game_port_defs.vh ----
// constants shared by the game port motion decoder and its axis counter
`ifndef GAME_PORT_DEFS_VH
`define GAME_PORT_DEFS_VH

// apb register byte offsets
`define OFS_PORT0_MOTION_COUNTERS 8'h00
`define OFS_PORT1_MOTION_COUNTERS 8'h04
`define OFS_IO_PORT_A_DATA        8'h08
`define OFS_IO_PORT_A_DIRECTION   8'h0c
`define OFS_PORT_MODE             8'h10

// reset values
`define RST_MOTION_COUNT          8'h00
`define RST_IO_PORT_A_DATA        8'h00
`define RST_IO_PORT_A_DIRECTION   8'h00
`define RST_PORT_MODE             2'h0
`define RST_SYNC_LEVEL            1'h1

// motion register field positions
`define Y_COUNT_MSB               15
`define Y_COUNT_LSB               8
`define X_COUNT_MSB               7
`define X_COUNT_LSB               0

// joystick encoding bit positions
`define JOY_LEFT_BIT              9
`define JOY_FWD_XOR_BIT           8
`define JOY_RIGHT_BIT             1
`define JOY_BACK_XOR_BIT          0

// port a fire button bit positions
`define FIRE_PORT0_BIT            7
`define FIRE_PORT1_BIT            6

// port mode register bit positions (1 = joystick, 0 = mouse)
`define MODE_PORT0_BIT            0
`define MODE_PORT1_BIT            1

// axis counter start-up settle count
`define SETTLE_DONE               2'h3

`endif

// ---- rtl/quad_axis_counter.v ----
// one quadrature decoder and 8-bit up/down displacement counter
`timescale 1ns/100ps
`include "game_port_defs.vh"

module quad_axis_counter (
    input  wire       sys_clk,
    input  wire       rst_b,
    input  wire       phase_a,
    input  wire       phase_b,
    output wire [7:0] count
);

    reg  [7:0] count_q;
    reg  [7:0] count_d;
    reg        prev_a_q;
    reg        prev_b_q;
    reg  [1:0] settle_q;
    wire       step_up;
    wire       step_down;

    // a leading b steps up, b leading a steps down; a double change is
    // a missed edge and is dropped rather than guessed
    assign step_up   = prev_b_q ^ phase_a;
    assign step_down = prev_a_q ^ phase_b;

    // next count, wrapping in 8 bits
    always @* begin
        count_d = count_q;
        if (settle_q == `SETTLE_DONE && (step_up ^ step_down)) begin
            if (step_up) begin
                count_d = count_q + 8'h01;
            end else begin
                count_d = count_q - 8'h01;
            end
        end
    end

    // settle counter hides the jump from reset levels to the real pin levels
    always @(posedge sys_clk) begin
        if (!rst_b) begin
            count_q  <= `RST_MOTION_COUNT;
            prev_a_q <= `RST_SYNC_LEVEL;
            prev_b_q <= `RST_SYNC_LEVEL;
            settle_q <= 2'h0;
        end else begin
            count_q  <= count_d;
            prev_a_q <= phase_a;
            prev_b_q <= phase_b;
            if (settle_q != `SETTLE_DONE) begin
                settle_q <= settle_q + 2'h1;
            end
        end
    end

    assign count = count_q;

endmodule // quad_axis_counter

// ---- rtl/game_port_motion_decoder.v ----
// two-port game controller input logic: quadrature counters, joystick encoding, port a
`timescale 1ns/100ps
`include "game_port_defs.vh"

// What this block does
// - motion register holds Y high, X low
// - up/left decrement, down/right increment
// - vertical pins drive 15:8, horizontal 7:0
// - counters valid and readable at any time
// - joystick bits: 9^8 fwd, 9 left, 1^0 back, 1 right
// - left/right pins double as buttons
// - fire buttons on port A bits 7, 6
// - fire bits show current switch state while direction bits 7:6 are clear
// - two independent ports, right feeds port 1

// register map, one 32-bit word each, unused upper bits read zero
//   0x00 port 0 motion counters, read only
//   0x04 port 1 motion counters, read only
//   0x08 port a data: latch on write, pin or latch on read
//   0x0c port a direction: 1 = output, reset leaves all inputs
//   0x10 controller mode: bit 0 port 0, bit 1 port 1, 1 = joystick
// a write to a counter or any access to an unmapped word gets pslverr

// connector pins, the same on both ports
//   pin 1 y pulse, or the forward switch
//   pin 2 x pulse, or the back switch
//   pin 3 y quadrature, or the left switch
//   pin 4 x quadrature, or the right switch
//   pin 6 fire button, low while pressed
//   pins 5 and 9 are not used by this block
// the left connector is port 0, the right connector port 1

module game_port_motion_decoder (
    input  wire        sys_clk,
    input  wire        rst_b,
    // apb slave
    input  wire [7:0]  paddr,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [31:0] pwdata,
    output wire [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    // left connector (port 0): pins 1..4 and fire, all active low switches or pulses
    input  wire        port0_y_pulse,
    input  wire        port0_x_pulse,
    input  wire        port0_y_quad_b_input,
    input  wire        port0_x_quad_b_input,
    input  wire        port0_primary_button_n,
    // right connector (port 1)
    input  wire        port1_y_pulse,
    input  wire        port1_x_pulse,
    input  wire        port1_y_quad_b_input,
    input  wire        port1_x_quad_b_input,
    input  wire        port1_primary_button_n,
    // remaining general purpose port a pins 5:0
    input  wire [5:0]  io_port_a_i,
    output wire [5:0]  io_port_a_o,
    output wire [5:0]  io_port_a_oe_n
);

    // synchroniser stages for 4 axes x 2 phases, 2 fire buttons, 6 port pins
    reg  [15:0] sync1_q;
    reg  [15:0] sync2_q;
    wire [15:0] raw_pins;

    // axis order: 0 = port0 x, 1 = port0 y, 2 = port1 x, 3 = port1 y
    wire [3:0]  axis_a;
    wire [3:0]  axis_b;
    wire [31:0] axis_count;

    wire        fire0_s;
    wire        fire1_s;
    wire [5:0]  pins_s;

    reg  [7:0]  port_a_data_q;
    reg  [7:0]  port_a_dir_q;
    reg  [1:0]  port_mode_q;

    wire [15:0] port0_word;
    wire [15:0] port1_word;
    wire [31:0] port_words;
    wire [7:0]  port_a_pins;
    wire [7:0]  port_a_read;

    reg  [31:0] prdata_q;
    reg  [31:0] rdata_d;
    reg         pslverr_q;
    reg         decode_err;

    wire        setup_phase;
    wire        write_strobe;
    wire        counter_hit;
    wire        refuse_d;
    wire        wr_port_a_data;
    wire        wr_port_a_dir;
    wire        wr_port_mode;

    // pin vector, one place to see which pin lands on which sync bit
    assign raw_pins = {io_port_a_i,
                       port1_primary_button_n, port0_primary_button_n,
                       port1_y_quad_b_input, port1_y_pulse,
                       port1_x_quad_b_input, port1_x_pulse,
                       port0_y_quad_b_input, port0_y_pulse,
                       port0_x_quad_b_input, port0_x_pulse};

    // two-flop sync
    // stage one feeds stage two only; idle pins are pulled high, so reset to one
    always @(posedge sys_clk) begin
        if (!rst_b) begin
            sync1_q <= 16'hffff;
            sync2_q <= 16'hffff;
        end else begin
            sync1_q <= raw_pins;
            sync2_q <= sync1_q;
        end
    end

    // split the synchronised vector back into its groups
    assign fire0_s = sync2_q[8];
    assign fire1_s = sync2_q[9];
    assign pins_s  = sync2_q[15:10];

    // independent axes
    // each axis takes its pulse pin as phase a and its quadrature pin as phase b
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : axis
            assign axis_a[g] = sync2_q[2*g];
            assign axis_b[g] = sync2_q[2*g+1];
            quad_axis_counter u_count (
                .sys_clk (sys_clk),
                .rst_b   (rst_b),
                .phase_a (axis_a[g]),
                .phase_b (axis_b[g]),
                .count   (axis_count[8*g+7:8*g])
            );
        end
    endgenerate

    // per-port register word; port g owns axis 2g (x) and axis 2g+1 (y)
    generate
        for (g = 0; g < 2; g = g + 1) begin : ctl_port
            wire        fwd_on;
            wire        back_on;
            wire        left_on;
            wire        right_on;
            wire [15:0] joy_word;
            wire [15:0] mouse_word;

            // switches close to ground, so a pressed switch reads one after inversion
            assign fwd_on   = ~axis_a[2*g+1];
            assign back_on  = ~axis_a[2*g];
            assign left_on  = ~axis_b[2*g+1];
            assign right_on = ~axis_b[2*g];

            // left/right bits also read as buttons
            // the xor coding lets one register serve both controller kinds
            assign joy_word[`JOY_LEFT_BIT]     = left_on;
            assign joy_word[`JOY_FWD_XOR_BIT]  = left_on ^ fwd_on;
            assign joy_word[`JOY_RIGHT_BIT]    = right_on;
            assign joy_word[`JOY_BACK_XOR_BIT] = right_on ^ back_on;
            assign joy_word[15:10]             = 6'h00;
            assign joy_word[7:2]               = 6'h00;

            // y high byte, x low byte
            // vertical to 15:8, horizontal to 7:0
            assign mouse_word[`Y_COUNT_MSB:`Y_COUNT_LSB] = axis_count[16*g+15:16*g+8];
            assign mouse_word[`X_COUNT_MSB:`X_COUNT_LSB] = axis_count[16*g+7:16*g];

            // both views stay live, so a mode change shows on the very next read
            assign port_words[16*g+15:16*g] = port_mode_q[g] ? joy_word : mouse_word;
        end
    endgenerate

    // port 1 is fed by the right connector
    assign port0_word = port_words[15:0];
    assign port1_word = port_words[31:16];

    // fire bits on port a
    // fire buttons sit on bits 7 and 6, the general pins below them
    assign port_a_pins[`FIRE_PORT0_BIT] = fire0_s;
    assign port_a_pins[`FIRE_PORT1_BIT] = fire1_s;
    assign port_a_pins[5:0]             = pins_s;

    // live switch state on input bits, data latch on output bits
    // input bits show the pin, output bits echo the data latch; the fire
    // pins are never driven, so setting them to output only hides the button
    generate
        for (g = 0; g < 8; g = g + 1) begin : port_a_bit
            assign port_a_read[g] = port_a_dir_q[g] ? port_a_data_q[g] : port_a_pins[g];
        end
    endgenerate

    // general pins: drive only where the direction bit is set
    assign io_port_a_o    = port_a_data_q[5:0];
    assign io_port_a_oe_n = ~port_a_dir_q[5:0];

    // apb phases
    assign setup_phase  = psel & ~penable;
    assign write_strobe = psel & penable & pwrite;

    // counters are read-only; a write to them is refused, not dropped silently
    assign counter_hit = (paddr == `OFS_PORT0_MOTION_COUNTERS) ||
                         (paddr == `OFS_PORT1_MOTION_COUNTERS);
    assign refuse_d    = decode_err | (pwrite & counter_hit);

    // one write enable per writable register
    assign wr_port_a_data = write_strobe & (paddr == `OFS_IO_PORT_A_DATA);
    assign wr_port_a_dir  = write_strobe & (paddr == `OFS_IO_PORT_A_DIRECTION);
    assign wr_port_mode   = write_strobe & (paddr == `OFS_PORT_MODE);

    // read at any time
    // read mux; counters are sampled in the setup cycle, no frame timing involved
    always @* begin
        rdata_d    = 32'h00000000;
        decode_err = 1'b0;
        case (paddr)
            `OFS_PORT0_MOTION_COUNTERS: begin
                rdata_d = {16'h0000, port0_word};
            end
            `OFS_PORT1_MOTION_COUNTERS: begin
                rdata_d = {16'h0000, port1_word};
            end
            `OFS_IO_PORT_A_DATA: begin
                rdata_d = {24'h000000, port_a_read};
            end
            `OFS_IO_PORT_A_DIRECTION: begin
                rdata_d = {24'h000000, port_a_dir_q};
            end
            `OFS_PORT_MODE: begin
                rdata_d = {30'h0, port_mode_q};
            end
            default: begin
                decode_err = 1'b1;
            end
        endcase
    end

    // read data captured at the setup edge, so prdata comes from a flop
    // while the slave still answers with no wait state
    // writes capture zero so a stale read value never leaks
    always @(posedge sys_clk) begin
        if (!rst_b) begin
            prdata_q <= 32'h00000000;
        end else if (setup_phase) begin
            prdata_q <= pwrite ? 32'h00000000 : rdata_d;
        end
    end

    // refusal flag, captured with the read data and shown in the access cycle
    always @(posedge sys_clk) begin
        if (!rst_b) begin
            pslverr_q <= 1'b0;
        end else if (setup_phase) begin
            pslverr_q <= refuse_d;
        end
    end

    // direction bits 7:6 clear for fire input
    // whole-byte write, software keeps other bits
    // direction register; reset leaves every pin an input
    always @(posedge sys_clk) begin
        if (!rst_b) begin
            port_a_dir_q <= `RST_IO_PORT_A_DIRECTION;
        end else if (wr_port_a_dir) begin
            port_a_dir_q <= pwdata[7:0];
        end
    end

    // port a data latch, driven onto pins only where the direction bit is set
    always @(posedge sys_clk) begin
        if (!rst_b) begin
            port_a_data_q <= `RST_IO_PORT_A_DATA;
        end else if (wr_port_a_data) begin
            port_a_data_q <= pwdata[7:0];
        end
    end

    // controller mode, one bit per port; reset gives mouse mode on both
    always @(posedge sys_clk) begin
        if (!rst_b) begin
            port_mode_q <= `RST_PORT_MODE;
        end else if (wr_port_mode) begin
            port_mode_q <= pwdata[1:0];
        end
    end

    // zero-wait answer in every access cycle
    assign pready  = psel & penable;
    assign prdata  = prdata_q;
    assign pslverr = pslverr_q & psel & penable;

endmodule // game_port_motion_decoder

// ---- verif/game_port_motion_decoder_props.sv ----
// checker for the decoder bus and port a pins
`timescale 1ns/100ps

module game_port_motion_decoder_props (
    input wire        sys_clk,
    input wire        rst_b,
    input wire [7:0]  paddr,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire        pready,
    input wire        pslverr,
    input wire [5:0]  io_port_a_o,
    input wire [5:0]  io_port_a_oe_n
);
    // single clock domain, one default for every check
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    wire acc = psel && penable;
    wire rd  = acc && !pwrite;
    wire wr  = acc && pwrite;
    reset_clear_a: assert property ($rose(rst_b) |-> prdata == 32'h0 && io_port_a_oe_n == 6'h3f)
        else $error("reset state");
    zero_wait_a: assert property (pready == acc) else $error("pready");
    data_hold_a: assert property (acc |=> $stable(prdata)) else $error("prdata moved");
    motion_width_a: assert property (rd && paddr < 8'h08 |-> prdata[31:16] == 16'h0)
        else $error("motion upper");
    ro_write_a: assert property (wr && paddr < 8'h08 |-> pslverr) else $error("ro write");
    port_width_a: assert property (rd && paddr == 8'h08 |-> prdata[31:8] == 24'h0)
        else $error("port upper");
    data_latch_a: assert property (wr && paddr == 8'h08 |=> io_port_a_o == $past(pwdata[5:0]))
        else $error("latch");
    dir_enable_a: assert property (wr && paddr == 8'h0c |=> io_port_a_oe_n == ~$past(pwdata[5:0]))
        else $error("direction");
    // refused access reads zero, and never outside an access
    unmapped_a: assert property (acc && paddr > 8'h10 |-> pslverr && (pwrite || prdata == 32'h0))
        else $error("unmapped");
    quiet_err_a: assert property (!acc |-> !pslverr) else $error("stray error");
endmodule // game_port_motion_decoder_props

bind game_port_motion_decoder game_port_motion_decoder_props u_props (
    .sys_clk(sys_clk), .rst_b(rst_b), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .io_port_a_o(io_port_a_o), .io_port_a_oe_n(io_port_a_oe_n)
);

// ---- verif/game_ctrl_model.sv ----
// behavioural mouse and joystick on one connector
`timescale 1ns/100ps

module game_ctrl_model (
    input  wire sys_clk,
    output reg  y_pulse,
    output reg  x_pulse,
    output reg  y_quad_b,
    output reg  x_quad_b,
    output reg  fire_n
);
    // phase index per axis; 2 means both lines high, the open-switch level
    reg [1:0] gy = 2'h2;
    reg [1:0] gx = 2'h2;
    initial {y_pulse, x_pulse, y_quad_b, x_quad_b, fire_n} = 5'h1f;
    // one phase step, held past the synchroniser
    task automatic step(input bit vert, input bit inc);
        if (vert)
            gy = inc ? gy + 2'h1 : gy - 2'h1;
        else
            gx = inc ? gx + 2'h1 : gx - 2'h1;
        {y_pulse, y_quad_b, x_pulse, x_quad_b} <= {gy[1] ^ gy[0], gy[1], gx[1] ^ gx[0], gx[1]};
        repeat (5) @(posedge sys_clk);
    endtask
    // switches pull to ground; sw is {right, left, back, forward}
    task automatic joy(input [3:0] sw);
        {x_quad_b, y_quad_b, x_pulse, y_pulse} <= ~sw;
        repeat (5) @(posedge sys_clk);
    endtask
    task automatic fire(input bit down);
        fire_n <= !down;
        repeat (5) @(posedge sys_clk);
    endtask
endmodule // game_ctrl_model

// ---- verif/game_port_motion_decoder_tb_top.sv ----
// self-checking bench for the game port motion decoder
`timescale 1ns/100ps

module game_port_motion_decoder_tb_top;
    reg          sys_clk = 1'b0;
    reg          rst_b = 1'b0;
    reg  [7:0]   paddr = 8'h00;
    reg          psel = 1'b0;
    reg          penable = 1'b0;
    reg          pwrite = 1'b0;
    reg  [31:0]  pwdata = 32'h0;
    reg  [5:0]   pins_a = 6'h2d;
    wire [31:0]  prdata;
    wire         pready;
    wire         pslverr;
    wire [5:0]   port_a_o;
    wire [5:0]   port_a_oe_n;
    wire [4:0]   c0;
    wire [4:0]   c1;
    int          n_fail = 0;
    int          check_count = 0;
    logic [31:0] d;
    logic [31:0] d0;
    logic        e;

    always #10 sys_clk = ~sys_clk;

    game_ctrl_model m0 (.sys_clk(sys_clk), .y_pulse(c0[0]), .x_pulse(c0[1]), .y_quad_b(c0[2]),
        .x_quad_b(c0[3]), .fire_n(c0[4]));
    game_ctrl_model m1 (.sys_clk(sys_clk), .y_pulse(c1[0]), .x_pulse(c1[1]), .y_quad_b(c1[2]),
        .x_quad_b(c1[3]), .fire_n(c1[4]));
    game_port_motion_decoder uut (
        .sys_clk(sys_clk), .rst_b(rst_b), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .port0_y_pulse(c0[0]), .port0_x_pulse(c0[1]), .port0_y_quad_b_input(c0[2]),
        .port0_x_quad_b_input(c0[3]), .port0_primary_button_n(c0[4]),
        .port1_y_pulse(c1[0]), .port1_x_pulse(c1[1]), .port1_y_quad_b_input(c1[2]),
        .port1_x_quad_b_input(c1[3]), .port1_primary_button_n(c1[4]),
        .io_port_a_i(pins_a), .io_port_a_o(port_a_o), .io_port_a_oe_n(port_a_oe_n));

    task automatic summarize;
        $display("checks %0d fails %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    // one transfer, then an idle cycle so calls never collide
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, wr, a, wd};
        @(posedge sys_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) begin
            n_fail++;
            $display("BAD %0t no ready", $time);
            summarize();
        end
        d = prdata;
        e = pslverr;
        {psel, penable} <= 2'b00;
        @(posedge sys_clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic err);
        apb(1'b0, a, 32'h0);
        chk(d, exp);
        chk({31'h0, e}, {31'h0, err});
    endtask

    task automatic t_reset;
        rd(8'h00, 32'h0, 1'b0);
        rd(8'h04, 32'h0, 1'b0);
        rd(8'h0c, 32'h0, 1'b0);
        rd(8'h10, 32'h0, 1'b0);
        rd(8'h14, 32'h0, 1'b1);
        apb(1'b1, 8'h00, 32'h1234);
        chk({31'h0, e}, 32'h1);
        rd(8'h00, 32'h0, 1'b0);
    endtask
    task automatic t_mouse;
        repeat (2) m0.step(1'b1, 1'b0);
        m0.step(1'b0, 1'b0);
        repeat (3) m1.step(1'b0, 1'b1);
        m1.step(1'b1, 1'b1);
        rd(8'h04, 32'h0103, 1'b0);
        rd(8'h00, 32'hfeff, 1'b0);
        d0 = d;
        repeat (2) m0.step(1'b0, 1'b1);
        apb(1'b0, 8'h00, 32'h0);
        chk({24'h0, d[7:0] - d0[7:0]}, 32'h2);
    endtask
    task automatic t_fire;
        apb(1'b1, 8'h08, 32'hea);
        apb(1'b1, 8'h0c, 32'hd5);
        chk({20'h0, port_a_oe_n, port_a_o}, {20'h0, 6'h2a, 6'h2a});
        m0.fire(1'b1);
        apb(1'b0, 8'h08, 32'h0);
        chk({30'h0, d[7:6]}, 32'h3);
        apb(1'b0, 8'h0c, 32'h0);
        apb(1'b1, 8'h0c, d & 32'h3f);
        chk({26'h0, port_a_oe_n}, 32'h2a);
        apb(1'b0, 8'h08, 32'h0);
        chk({30'h0, d[7:6]}, 32'h1);
        chk({26'h0, d[5:0]}, 32'h28);
        m0.fire(1'b0);
        m1.fire(1'b1);
        apb(1'b0, 8'h08, 32'h0);
        chk({30'h0, d[7:6]}, 32'h2);
    endtask
    task automatic t_joy;
        logic [31:0] tbl [4] = '{32'h100, 32'h1, 32'h300, 32'h3};
        apb(1'b1, 8'h10, 32'h3);
        rd(8'h10, 32'h3, 1'b0);
        for (int i = 0; i < 4; i++) begin
            m0.joy(4'h1 << i);
            m1.joy(4'h1 << i);
            rd(8'h00, tbl[i], 1'b0);
            rd(8'h04, tbl[i], 1'b0);
        end
    endtask

    initial begin
        repeat (2) @(posedge sys_clk);
        rst_b <= 1'b1;
        repeat (6) @(posedge sys_clk);
        t_reset();
        t_mouse();
        t_fire();
        t_joy();
        summarize();
    end
endmodule // game_port_motion_decoder_tb_top
